// file: bench/phy_id_and_an_advertise_regs_test.sv
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %0t ns: got %h expected %h", $time, (got), (exp)); end end

module phy_id_and_an_advertise_regs_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [4:0] ADDR_A = 5'h01;
  localparam logic [4:0] ADDR_B = 5'h02;

  logic                  clk;
  logic                  srst;
  pia_pkg::pia_strap_t   strap;
  pia_pkg::pia_partner_t partner;
  pia_pkg::pia_adv_t     adv;
  logic [1:0]            pause_resolved;
  logic                  mdc;
  logic                  drv_bit;
  logic                  drv_en;
  logic                  out_a;
  logic                  oe_n_a;
  logic                  out_b;
  logic                  oe_n_b;
  wire logic             line;
  int                    err_total;
  int                    comparisons;
  logic [15:0]           rd;
  logic                  ta_ok;
  int                    bits [7] = '{15, 13, 11, 10, 8, 7, 6};
  logic [6:0]            pt [5] = '{7'h7f, 7'h5e, 7'h6d, 7'h2c, 7'h78};

  // Shared line with pull-up: any party driving low wins
  assign line = (drv_en ? drv_bit : 1'b1) & (oe_n_a | out_a) & (oe_n_b | out_b);

  pia_mgmt_model MGMT (.clk(clk), .mdc(mdc), .drv_bit(drv_bit), .drv_en(drv_en), .line(line));

  pia_regs #(.ID_ZERO(1'b0)) DUT (
    .clk(clk), .srst(srst), .phy_addr(ADDR_A), .strap(strap), .mdc(mdc), .mdio_in(line),
    .mdio_out(out_a), .mdio_oe_n(oe_n_a), .partner(partner), .adv(adv),
    .pause_resolved(pause_resolved));

  // Second device on the same line, built to return a zero identifier
  pia_regs #(.ID_ZERO(1'b1)) DUT2 (
    .clk(clk), .srst(srst), .phy_addr(ADDR_B), .strap(strap), .mdc(mdc), .mdio_in(line),
    .mdio_out(out_b), .mdio_oe_n(oe_n_b), .partner(partner), .adv(),
    .pause_resolved());

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic rd_reg(input logic [4:0] pa, input logic [4:0] ra);
    MGMT.xfer(pia_pkg::OP_READ, pa, ra, 16'h0000, 32, rd, ta_ok);
  endtask

  task automatic wr_reg(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
    MGMT.xfer(pia_pkg::OP_WRITE, pa, ra, wd, 32, rd, ta_ok);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    err_total = 0;
    comparisons = 0;
    srst = 1'b1;
    strap = 3'b101;
    partner = '0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    `CHK(adv, {4'h0, strap})
    rd_reg(ADDR_A, pia_pkg::REG_ADV);
    `CHK(rd, {7'h00, strap, 6'h00})
    $display("test reset_values done");

    rd_reg(ADDR_A, pia_pkg::REG_ID_HIGH);
    `CHK(ta_ok, 1'b1)
    `CHK(rd, pia_pkg::ORG_ID_BITS[21:6])
    wr_reg(ADDR_A, pia_pkg::REG_ID_LOW, 16'h0000);
    wr_reg(ADDR_A, pia_pkg::REG_ID_HIGH, 16'hffff);
    rd_reg(ADDR_A, pia_pkg::REG_ID_LOW);
    `CHK(rd[15:10], pia_pkg::ORG_ID_BITS[5:0])
    `CHK(rd[9:4], pia_pkg::VENDOR_MODEL)
    `CHK(rd[3:0], pia_pkg::MODEL_REVISION)
    rd_reg(ADDR_A, pia_pkg::REG_ID_HIGH);
    `CHK(rd, pia_pkg::ORG_ID_BITS[21:6])
    rd_reg(ADDR_B, pia_pkg::REG_ID_HIGH);
    `CHK({ta_ok, rd}, 17'h10000)
    rd_reg(ADDR_B, pia_pkg::REG_ID_LOW);
    `CHK({ta_ok, rd}, 17'h10000)
    $display("test identifier done");

    for (int k = 0; k < 7; k++) begin
      wr_reg(ADDR_A, pia_pkg::REG_ADV, 16'h0001 << bits[k]);
      `CHK(adv, 7'h40 >> k)
      rd_reg(ADDR_A, pia_pkg::REG_ADV);
      `CHK(rd, 16'h0001 << bits[k])
    end
    // Bit 12 kept at 0 on write
    wr_reg(ADDR_A, pia_pkg::REG_ADV, 16'hefff);
    wr_reg(5'h07, pia_pkg::REG_ADV, 16'h0000);
    `CHK(adv, 7'h7f)
    rd_reg(ADDR_A, pia_pkg::REG_ADV);
    `CHK(rd[14], 1'b0)
    `CHK(rd[12], 1'b0)
    `CHK(rd[9], 1'b0)
    `CHK(rd, 16'hadc0)
    MGMT.xfer(pia_pkg::OP_READ, ADDR_A, pia_pkg::REG_ADV, 16'h0000, 1, rd, ta_ok);
    `CHK(rd, 16'hadc0)
    rd_reg(5'h07, pia_pkg::REG_ADV);
    `CHK(ta_ok, 1'b0)
    $display("test advertisement done");

    for (int k = 0; k < 5; k++) begin
      partner = '0;
      wr_reg(ADDR_A, pia_pkg::REG_ADV, {4'h0, pt[k][6:5], 10'h000});
      // Renegotiation after the write brings the new values into use
      partner = {pt[k][4:2], 1'b1};
      repeat (4) @(negedge clk);
      `CHK(pause_resolved, pt[k][1:0])
    end
    $display("test pause_resolution done");

    strap = 3'b010;
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    `CHK(adv, 7'h02)
    `CHK(pause_resolved, 2'h0)
    rd_reg(ADDR_A, pia_pkg::REG_ADV);
    `CHK(rd, 16'h0080)
    $display("test second_reset done");
    report_and_stop();
  end
endmodule

`default_nettype wire

// file: bench/pia_mgmt_model.sv
`default_nettype none

// ****************************************************************
// Station management controller on the serial management line
// ****************************************************************
module pia_mgmt_model (
  input  wire logic clk,
  output logic      mdc,
  output logic      drv_bit,
  output logic      drv_en,
  input  wire logic line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    mdc = 1'b0;
    drv_bit = 1'b1;
    drv_en = 1'b0;
  end

  // Each mdc level lasts two clk cycles, twice the one cycle the device needs to see a level
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, input int npre, output logic [15:0] rd,
                      output logic ta_ok);
    logic [31:0] fr;
    logic        rdf;
    fr = {2'b01, op, pa, ra, 2'b10, wd};
    rdf = (op == pia_pkg::OP_READ);
    rd = 16'h0000;
    ta_ok = 1'b1;
    for (int i = -npre; i < 32; i++) begin
      @(negedge clk);
      mdc = 1'b0;
      // Released line floats to the pull-up level
      drv_en = !(rdf && i >= 14);
      drv_bit = (i < 0) ? 1'b1 : fr[31-i];
      repeat (2) @(negedge clk);
      if (rdf && i == 15) begin
        ta_ok = (line === 1'b0);
      end
      if (rdf && i >= 16) begin
        rd[31-i] = line;
      end
      mdc = 1'b1;
      @(negedge clk);
    end
    @(negedge clk);
    drv_en = 1'b0;
    repeat (2) @(negedge clk);
  endtask
endmodule

`default_nettype wire

// file: pkg/pia_pkg.sv
// What this block does
// - Identifier is the organisation bits, model number and revision joined together
// - A build option returns zero in all 32 identifier bits
// - First identifier register holds identifier bits 3 to 18 in bits 15..0
// - Second identifier register holds identifier bits 19 to 24 in bits 15..10
// - Second identifier register holds six-bit model number in bits 9..4
// - Second identifier register holds four-bit revision in bits 3..0
// - Advertisement bit 15, read-write, reset 0, requests next page
// - Advertisement bit 14 ignores writes and reads 0
// - Advertisement bit 13, read-write, reset 0, advertises remote fault
// - Advertisement bit 12 written 0 by controller, reads 0
// - Advertisement bit 11, read-write, reset 0, asymmetric pause
// - Advertisement bit 10, read-write, reset 0, symmetric pause
// - Resolved pause outcome driven on the two-bit pause_resolved output
// - Advertisement bit 9 is read-only zero
// - Advertisement bits 8, 7, 6 read-write with strap reset values
`default_nettype none

package pia_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0] REG_ID_HIGH = 5'h02;
  localparam logic [4:0] REG_ID_LOW  = 5'h03;
  localparam logic [4:0] REG_ADV     = 5'h04;

  // ****************************************************************
  // Advertisement field positions
  // ****************************************************************
  localparam int ADV_NEXT_PAGE   = 15;
  localparam int ADV_RSVD_IEEE   = 14;
  localparam int ADV_REMOTE_FLT  = 13;
  localparam int ADV_RSVD_FUTURE = 12;
  localparam int ADV_ASYM_PAUSE  = 11;
  localparam int ADV_PAUSE       = 10;
  localparam int ADV_FOUR_PAIR   = 9;
  localparam int ADV_FAST_FD     = 8;
  localparam int ADV_FAST_HD     = 7;
  localparam int ADV_TEN_FD      = 6;

  // ****************************************************************
  // Identifier contents (values arbitrary, not any real maker's)
  // ****************************************************************
  localparam logic [21:0] ORG_ID_BITS    = 22'h05a3c6;
  localparam logic [5:0]  VENDOR_MODEL   = 6'h15;
  localparam logic [3:0]  MODEL_REVISION = 4'h3;

  // ****************************************************************
  // Management frame
  // ****************************************************************
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [3:0] HDR_BITS      = 4'hd;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [3:0] DATA_LAST     = 4'hf;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_NEXT_PAGE = 1'h0;
  localparam logic RST_REMOTE    = 1'h0;
  localparam logic RST_ASYM      = 1'h0;
  localparam logic RST_PAUSE     = 1'h0;

  typedef enum logic [1:0] {
    PIA_IDLE,
    PIA_HDR,
    PIA_TA,
    PIA_DATA
  } pia_state_t;

  typedef struct packed {
    logic next_page_request;
    logic remote_fault_adv;
    logic asymmetric_pause_adv;
    logic pause_adv;
    logic fast_full_duplex_adv;
    logic fast_half_duplex_adv;
    logic ten_full_duplex_adv;
  } pia_adv_t;

  typedef struct packed {
    logic fast_full_duplex_adv;
    logic fast_half_duplex_adv;
    logic ten_full_duplex_adv;
  } pia_strap_t;

  typedef struct packed {
    logic lp_pause;
    logic lp_asym_pause;
    logic an_complete;
    logic full_duplex;
  } pia_partner_t;

endpackage

`default_nettype wire

// file: verilog/pia_regs.sv
`default_nettype none

module pia_regs #(
  parameter bit ID_ZERO = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [4:0]            phy_addr,
  input  wire pia_pkg::pia_strap_t   strap,
  input  wire logic                  mdc,
  input  wire logic                  mdio_in,
  output logic                       mdio_out,
  output logic                       mdio_oe_n,
  input  wire pia_pkg::pia_partner_t partner,
  output pia_pkg::pia_adv_t          adv,
  output logic [1:0]                 pause_resolved
);

  // ****************************************************************
  // Identifier and read mux
  // ****************************************************************
  function automatic logic [31:0] id_word();
    if (ID_ZERO)
      return 32'h00000000;
    return {pia_pkg::ORG_ID_BITS, pia_pkg::VENDOR_MODEL,
            pia_pkg::MODEL_REVISION};
  endfunction

  function automatic logic [15:0] adv_word(input pia_pkg::pia_adv_t a);
    logic [15:0] w;
    w = 16'h0000; // Reserved, four-pair and omitted low bits read 0
    w[pia_pkg::ADV_NEXT_PAGE]  = a.next_page_request;
    w[pia_pkg::ADV_REMOTE_FLT] = a.remote_fault_adv;
    w[pia_pkg::ADV_ASYM_PAUSE] = a.asymmetric_pause_adv;
    w[pia_pkg::ADV_PAUSE]      = a.pause_adv;
    w[pia_pkg::ADV_FAST_FD]    = a.fast_full_duplex_adv;
    w[pia_pkg::ADV_FAST_HD]    = a.fast_half_duplex_adv;
    w[pia_pkg::ADV_TEN_FD]     = a.ten_full_duplex_adv;
    return w;
  endfunction

  function automatic logic [15:0] rd_word(input logic [4:0] ra, input pia_pkg::pia_adv_t a);
    logic [31:0] id;
    id = id_word();
    case (ra)
      pia_pkg::REG_ID_HIGH: return id[31:16];
      pia_pkg::REG_ID_LOW:  return id[15:0];
      pia_pkg::REG_ADV:     return adv_word(a);
      default:              return 16'h0000;
    endcase
  endfunction

  // ****************************************************************
  // Management frame decoder
  // ****************************************************************
  pia_pkg::pia_state_t state_q;
  logic [5:0]          ones_q;
  logic                pre_ok_q;
  logic [3:0]          cnt_q;
  logic [12:0]         hdr_q;
  logic [15:0]         sh_q;
  logic                mine_q;
  logic                rd_q;
  logic                mdc_q;
  logic                rise;
  logic [12:0]         hdr_d;
  logic                wr_commit;

  assign rise  = mdc & ~mdc_q;
  assign hdr_d = {hdr_q[11:0], mdio_in};
  assign wr_commit = rise && state_q == pia_pkg::PIA_DATA && cnt_q == pia_pkg::DATA_LAST
                     && mine_q && !rd_q;

  // Tracks the pin in reset too: a clock left high must not read as a rise
  always_ff @(posedge clk) begin
    mdc_q <= mdc;
  end

  // Preamble: 32 ones after reset or after a bad start or opcode, then suppression allowed
  always_ff @(posedge clk) begin
    if (srst) begin
      ones_q   <= 6'h00;
      pre_ok_q <= 1'b0;
    end else if (rise) begin
      if (state_q != pia_pkg::PIA_IDLE)
        ones_q <= 6'h00;
      else if (mdio_in && ones_q != pia_pkg::PREAMBLE_ONES)
        ones_q <= ones_q + 6'h01;
      else if (!mdio_in && ones_q != pia_pkg::PREAMBLE_ONES)
        ones_q <= 6'h00;
      if (mdio_in && ones_q == pia_pkg::PREAMBLE_ONES - 6'h01)
        pre_ok_q <= 1'b1;
      else if (state_q == pia_pkg::PIA_HDR && cnt_q == pia_pkg::HDR_BITS - 4'h1
               && (hdr_d[11:10] != pia_pkg::OP_READ && hdr_d[11:10] != pia_pkg::OP_WRITE
                   || !hdr_d[12]))
        pre_ok_q <= 1'b0; // Bad start or opcode: demand full preamble again
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= pia_pkg::PIA_IDLE;
      cnt_q   <= 4'h0;
      hdr_q   <= 13'h0000;
      mine_q  <= 1'b0;
      rd_q    <= 1'b0;
    end else if (rise) begin
      case (state_q)
        pia_pkg::PIA_IDLE: begin
          cnt_q <= 4'h0;
          if (!mdio_in && (pre_ok_q || ones_q == pia_pkg::PREAMBLE_ONES))
            state_q <= pia_pkg::PIA_HDR;
        end
        pia_pkg::PIA_HDR: begin
          hdr_q <= hdr_d;
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == pia_pkg::HDR_BITS - 4'h1) begin
            cnt_q   <= 4'h0;
            rd_q    <= hdr_d[11:10] == pia_pkg::OP_READ;
            mine_q  <= hdr_d[9:5] == phy_addr;
            if (hdr_d[12] && (hdr_d[11:10] == pia_pkg::OP_READ
                              || hdr_d[11:10] == pia_pkg::OP_WRITE))
              state_q <= pia_pkg::PIA_TA;
            else
              state_q <= pia_pkg::PIA_IDLE;
          end
        end
        pia_pkg::PIA_TA: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'h1) begin
            cnt_q   <= 4'h0;
            state_q <= pia_pkg::PIA_DATA;
          end
        end
        pia_pkg::PIA_DATA: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == pia_pkg::DATA_LAST)
            state_q <= pia_pkg::PIA_IDLE;
        end
        default: state_q <= pia_pkg::PIA_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Data shifter and pin drive
  // ****************************************************************
  // Output changes on the rising edge, so the station sees a full
  // period of setup before it samples on the next rising edge.
  always_ff @(posedge clk) begin
    if (srst) begin
      sh_q      <= 16'h0000;
      mdio_out  <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else if (rise) begin
      if (state_q == pia_pkg::PIA_TA && mine_q && rd_q) begin
        if (cnt_q == 4'h0) begin
          mdio_oe_n <= 1'b0;
          mdio_out  <= 1'b0;
          sh_q      <= rd_word(hdr_q[4:0], adv); // Plain read, no side effect
        end else begin
          mdio_out <= sh_q[15];
          sh_q     <= {sh_q[14:0], 1'b0};
        end
      end else if (state_q == pia_pkg::PIA_DATA && rd_q) begin
        if (cnt_q == pia_pkg::DATA_LAST) begin
          mdio_oe_n <= 1'b1;
          mdio_out  <= 1'b1;
        end else begin
          mdio_out <= sh_q[15];
          sh_q     <= {sh_q[14:0], 1'b0};
        end
      end else if (state_q == pia_pkg::PIA_DATA) begin
        sh_q <= {sh_q[14:0], mdio_in};
      end else begin
        mdio_oe_n <= 1'b1;
        mdio_out  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Advertisement register
  // ****************************************************************
  logic [15:0] wdata;
  assign wdata = {sh_q[14:0], mdio_in};

  // Writes to identifier or unmapped offsets fall through untouched
  always_ff @(posedge clk) begin
    if (srst) begin
      adv.next_page_request    <= pia_pkg::RST_NEXT_PAGE;
      adv.remote_fault_adv     <= pia_pkg::RST_REMOTE;
      adv.asymmetric_pause_adv <= pia_pkg::RST_ASYM;
      adv.pause_adv            <= pia_pkg::RST_PAUSE;
      adv.fast_full_duplex_adv <= strap.fast_full_duplex_adv;
      adv.fast_half_duplex_adv <= strap.fast_half_duplex_adv;
      adv.ten_full_duplex_adv  <= strap.ten_full_duplex_adv;
    end else if (wr_commit && hdr_q[4:0] == pia_pkg::REG_ADV) begin
      // Bits 14, 12 and 9 have no storage; written values drop
      adv.next_page_request    <= wdata[pia_pkg::ADV_NEXT_PAGE];
      adv.remote_fault_adv     <= wdata[pia_pkg::ADV_REMOTE_FLT];
      adv.asymmetric_pause_adv <= wdata[pia_pkg::ADV_ASYM_PAUSE];
      adv.pause_adv            <= wdata[pia_pkg::ADV_PAUSE];
      adv.fast_full_duplex_adv <= wdata[pia_pkg::ADV_FAST_FD];
      adv.fast_half_duplex_adv <= wdata[pia_pkg::ADV_FAST_HD];
      adv.ten_full_duplex_adv  <= wdata[pia_pkg::ADV_TEN_FD];
    end
  end

  // ****************************************************************
  // Pause resolution, {transmit pause, receive pause}
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst)
      pause_resolved <= 2'h0;
    else if (!(partner.an_complete && partner.full_duplex))
      pause_resolved <= 2'h0;
    else if (adv.pause_adv && partner.lp_pause)
      pause_resolved <= 2'h3;
    else if (!adv.pause_adv && adv.asymmetric_pause_adv
             && partner.lp_pause && partner.lp_asym_pause)
      pause_resolved <= 2'h2;
    else if (adv.pause_adv && adv.asymmetric_pause_adv
             && !partner.lp_pause && partner.lp_asym_pause)
      pause_resolved <= 2'h1;
    else
      pause_resolved <= 2'h0;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Read view of the advertisement, as the shifter loads it
  logic [15:0] adv_rd;
  assign adv_rd = adv_word(adv);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_id_zero_opt: assert property (ID_ZERO |->
      rd_word(pia_pkg::REG_ID_HIGH, adv) == 16'h0000
      && rd_word(pia_pkg::REG_ID_LOW, adv) == 16'h0000)
    else $error("identifier not zero");
  chk_id_fields: assert property (!ID_ZERO |->
      rd_word(pia_pkg::REG_ID_LOW, adv) == {pia_pkg::ORG_ID_BITS[5:0],
      pia_pkg::VENDOR_MODEL, pia_pkg::MODEL_REVISION}
      && rd_word(pia_pkg::REG_ID_HIGH, adv) == pia_pkg::ORG_ID_BITS[21:6])
    else $error("identifier layout wrong");
  chk_adv_reserved: assert property (adv_rd[pia_pkg::ADV_RSVD_IEEE] == 1'b0
      && adv_rd[pia_pkg::ADV_RSVD_FUTURE] == 1'b0
      && adv_rd[pia_pkg::ADV_FOUR_PAIR] == 1'b0)
    else $error("reserved advertisement bit set");
  chk_adv_write: assert property (wr_commit && hdr_q[4:0] == pia_pkg::REG_ADV |=>
      adv_word(adv) == ($past(wdata) & 16'hadc0))
    else $error("advertisement write lost");
  chk_id_write_ignored: assert property (
      wr_commit && hdr_q[4:0] != pia_pkg::REG_ADV |=> $stable(adv))
    else $error("write to other offset changed advertisement");
  chk_strap_load: assert property (disable iff (1'b0) srst |=>
      adv.fast_full_duplex_adv == $past(strap.fast_full_duplex_adv)
      && adv.fast_half_duplex_adv == $past(strap.fast_half_duplex_adv)
      && adv.ten_full_duplex_adv == $past(strap.ten_full_duplex_adv)
      && !adv.next_page_request)
    else $error("strap reset value wrong");
  chk_read_drive: assert property (rise && state_q == pia_pkg::PIA_TA && cnt_q == 4'h1
      && mine_q && rd_q |=> !mdio_oe_n && mdio_out == $past(sh_q[15]))
    else $error("read data not driven");
  chk_read_release: assert property (!mdio_oe_n |-> mine_q && rd_q
      && (state_q == pia_pkg::PIA_DATA || state_q == pia_pkg::PIA_TA))
    else $error("pin driven outside read");
  chk_pause_sym: assert property (partner.an_complete && partner.full_duplex
      && adv.pause_adv && partner.lp_pause |=> pause_resolved == 2'h3)
    else $error("symmetric pause not resolved");

  // ****************************************************************
  // Pin, frame and pause checks
  // ****************************************************************
  // Turnaround: the first driven bit is a zero
  chk_ta_drive_low: assert property (rise && state_q == pia_pkg::PIA_TA && cnt_q == 4'h0
      && mine_q && rd_q |=> !mdio_oe_n && !mdio_out)
    else $error("turnaround bit not driven low");
  chk_read_end: assert property (rise && state_q == pia_pkg::PIA_DATA
      && cnt_q == pia_pkg::DATA_LAST && rd_q |=> mdio_oe_n && mdio_out)
    else $error("pin not released after last bit");
  chk_read_no_side: assert property (rise && state_q == pia_pkg::PIA_TA
      && cnt_q == 4'h0 && mine_q && rd_q |=> $stable(adv))
    else $error("read changed advertisement");
  // Without a full preamble since reset or since a bad start or opcode no frame may begin
  chk_preamble_gate: assert property (rise && state_q == pia_pkg::PIA_IDLE && !pre_ok_q
      && ones_q != pia_pkg::PREAMBLE_ONES |=> state_q == pia_pkg::PIA_IDLE)
    else $error("frame started without preamble");
  chk_frame_start: assert property (rise && state_q == pia_pkg::PIA_IDLE && !mdio_in
      && pre_ok_q |=> state_q == pia_pkg::PIA_HDR)
    else $error("suppressed preamble frame missed");
  chk_pause_off: assert property (!(partner.an_complete && partner.full_duplex)
      |=> pause_resolved == 2'h0)
    else $error("pause resolved without full duplex link");
  chk_pause_asym_tx: assert property (partner.an_complete && partner.full_duplex
      && !adv.pause_adv && adv.asymmetric_pause_adv
      && partner.lp_pause && partner.lp_asym_pause |=> pause_resolved == 2'h2)
    else $error("transmit-only pause not resolved");
  chk_pause_asym_rx: assert property (partner.an_complete && partner.full_duplex
      && adv.pause_adv && adv.asymmetric_pause_adv
      && !partner.lp_pause && partner.lp_asym_pause |=> pause_resolved == 2'h1)
    else $error("receive-only pause not resolved");

endmodule

`default_nettype wire
